//--- hdl/sem_pkg.sv
// Purpose: shared constants and carrier types for the semaphore unit
// Assumes: one 200 MHz system clock
// Notes:   byte addresses are those seen on the system bus
package sem_pkg;

  localparam int unsigned NUM_SEM    = 6;
  localparam logic [7:0]  SYS_BASE   = 8'h17;
  localparam logic [7:0]  SYS_LAST   = 8'h1C;
  localparam int unsigned LOCK_BIT   = 7;
  localparam int unsigned OWNER_BIT  = 6;
  localparam logic        LOCK_RST   = 1'b1;
  // owner flag codes: 1 = local cpu set it, 0 = system processor set it
  localparam logic        OWNER_LOC  = 1'b1;
  localparam logic        OWNER_SYS  = 1'b0;
  localparam int unsigned SYS_OWNED_IDX = 1; // register 1, zero based

  // one access request from the local cpu side
  typedef struct packed {
    logic       req;   // access strobe, one cycle
    logic       rd;    // 1 = read, 0 = write
    logic [2:0] idx;   // register index 0..5
  } sem_acc_t;

  // read answer to one side
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sem_rsp_t;

endpackage

//--- hdl/sem_cell.sv
`timescale 1ns/1ps
// Purpose: one test-and-set lock flag with owner flag and arbitration
// Assumes: at most one access per side per cycle
// Notes:   owner is stored as "local cpu set it"
module sem_cell #(
  parameter logic OWNER_INIT = 1'b1
) (
  input  wire logic clk_sys_i,  // system clock
  input  wire logic rst_i,      // async reset, active high
  input  wire logic loc_hit_i,  // local access to this cell
  input  wire logic loc_rd_i,   // local access is a read
  input  wire logic sys_hit_i,  // system access to this cell
  input  wire logic sys_rd_i,   // system access is a read
  output logic      lock_o,     // lock flag
  output logic      owner_o,    // 1 = local cpu set last
  output logic      sys_see_o   // lock flag as system side reads it
);

  logic lock_q;
  logic lock_d;
  logic owner_q;
  logic owner_d;
  logic loc_rd;
  logic loc_wr;
  logic sys_rd;
  logic sys_wr;

  assign loc_rd = loc_hit_i & loc_rd_i;
  assign loc_wr = loc_hit_i & ~loc_rd_i;
  assign sys_rd = sys_hit_i & sys_rd_i;
  assign sys_wr = sys_hit_i & ~sys_rd_i;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    lock_d  = lock_q;
    owner_d = owner_q;
    if (loc_wr && sys_wr) begin
      lock_d = 1'b0;                                     // R05
    end else if (loc_rd && sys_wr) begin
      lock_d = ~lock_q;                                  // R05
      if (!lock_q) owner_d = sem_pkg::OWNER_LOC;
    end else if (sys_rd && loc_wr) begin
      lock_d = ~lock_q;                                  // R05
      if (!lock_q) owner_d = sem_pkg::OWNER_SYS;
    end else if (loc_rd) begin
      // local wins a tie on a clear flag
      lock_d = 1'b1;                                     // R01 R04
      if (!lock_q) owner_d = sem_pkg::OWNER_LOC;         // R06
    end else if (sys_rd) begin
      lock_d = 1'b1;                                     // R01
      if (!lock_q) owner_d = sem_pkg::OWNER_SYS;         // R06
    end else if (loc_wr || sys_wr) begin
      lock_d = 1'b0;                                     // R02
    end
  end

  // system reads 1 when the local side took a clear flag this cycle
  assign sys_see_o = lock_q | loc_rd;                    // R03 R04

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q  <= sem_pkg::LOCK_RST;                      // R07
      owner_q <= OWNER_INIT;                             // R07
    end else begin
      lock_q  <= lock_d;
      owner_q <= owner_d;
    end
  end

  assign lock_o  = lock_q;
  assign owner_o = owner_q;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  tie_local_wins_a: assert property (  // R04
    @(posedge clk_sys_i) disable iff (rst_i)
    (loc_rd && sys_rd && !lock_q) |=> (lock_q && owner_q))
    else $error("tie on clear flag not won by local side");

  double_write_a: assert property (  // R05
    @(posedge clk_sys_i) disable iff (rst_i)
    (loc_wr && sys_wr) |=> !lock_q)
    else $error("two writes did not clear flag");

  rd_wr_toggle_a: assert property (  // R05
    @(posedge clk_sys_i) disable iff (rst_i)
    ((loc_rd && sys_wr) || (sys_rd && loc_wr)) |=>
      (lock_q != $past(lock_q)))
    else $error("read plus write did not invert flag");

endmodule // sem_cell

//--- hdl/sem_regs.sv
`timescale 1ns/1ps
// Purpose: six shared test-and-set semaphore registers, two sides
// Assumes: system select arrives as a level synchronous to clk_sys_i
// Notes:   read data is registered, one cycle after the access
//
// How it works
// [R01] a lone read returns the lock flag, then leaves it set
// [R02] a lone write clears the lock flag, data value ignored
// [R03] in a clash local reads true flag, system too unless both read clear
// [R04] both read clear: local gets 0 and wins, system 1, flag set
// [R05] two writes clear; read plus write inverts; reader gets original
// [R06] owner flag read-only; 1 to the side that set lock last
// [R07] reset sets all locks; local owns all but register 1
// [R08] lock in bit 7, owner in bit 6, bits 5..0 zero
// [R09] system addresses 0x17 to 0x1C map to the six registers
// [R10] system select marks one system access per assertion
// [R11] system select edge taken into clock domain; same cycle is a clash
module sem_regs #(
  parameter int unsigned NSEM = sem_pkg::NUM_SEM
) (
  input  wire logic             clk_sys_i,          // system clock
  input  wire logic             rst_i,              // async reset, high
  input  wire sem_pkg::sem_acc_t loc_acc_i,         // local cpu access
  output sem_pkg::sem_rsp_t     loc_rsp_o,          // local read answer
  input  wire logic             system_sel_i,       // system select, high
  input  wire logic             system_read_write_i,// 1 read, 0 write
  input  wire logic [7:0]       system_addr_i,      // system byte address
  output logic [7:0]            system_bus_lines_o, // system read data
  output logic                  system_bus_lines_oe_o, // drive enable
  output logic                  system_ack_o        // answer, one cycle
);

  // ---------------------------------------------------------------------
  // system select event
  // ---------------------------------------------------------------------
  logic       sel_q;
  logic       sys_evt;
  logic       sys_in_rng;
  logic [7:0] sys_off;
  logic [2:0] sys_idx;

  // rising edge of select is the one access event
  assign sys_evt    = system_sel_i & ~sel_q;                // R10 R11
  assign sys_in_rng = (system_addr_i >= sem_pkg::SYS_BASE) &&
                      (system_addr_i <= sem_pkg::SYS_LAST); // R09
  assign sys_off    = system_addr_i - sem_pkg::SYS_BASE;
  assign sys_idx    = sys_off[2:0];                         // R09

  // ---------------------------------------------------------------------
  // cells
  // ---------------------------------------------------------------------
  logic [NSEM-1:0] lock_v;
  logic [NSEM-1:0] owner_v;
  logic [NSEM-1:0] sys_see_v;
  logic [NSEM-1:0] loc_hit_v;
  logic [NSEM-1:0] sys_hit_v;

  for (genvar g = 0; g < NSEM; g++) begin : g_cell
    assign loc_hit_v[g] = loc_acc_i.req && (loc_acc_i.idx == 3'(g));
    // same cycle on both sides is arbitrated inside the cell
    assign sys_hit_v[g] = sys_evt && sys_in_rng &&
                          (sys_idx == 3'(g));               // R11
    sem_cell #(
      .OWNER_INIT((g == sem_pkg::SYS_OWNED_IDX) ?
                  sem_pkg::OWNER_SYS : sem_pkg::OWNER_LOC)  // R07
    ) u_cell (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .loc_hit_i (loc_hit_v[g]),
      .loc_rd_i  (loc_acc_i.rd),
      .sys_hit_i (sys_hit_v[g]),
      .sys_rd_i  (system_read_write_i),
      .lock_o    (lock_v[g]),
      .owner_o   (owner_v[g]),
      .sys_see_o (sys_see_v[g])
    );
  end

  // ---------------------------------------------------------------------
  // read data shaping
  // ---------------------------------------------------------------------
  logic       loc_ok;
  logic [7:0] loc_rdata;
  logic [7:0] sys_rdata;
  logic       sys_ok;
  logic       sys_rd_ok;
  logic       sys_wr_ok;
  logic       clash;

  assign loc_ok = loc_acc_i.idx < 3'(NSEM);
  // unmapped local index reads zero
  assign loc_rdata = loc_ok ?
    {lock_v[loc_acc_i.idx], owner_v[loc_acc_i.idx], 6'h00} : 8'h00; // R08
  // system side sees the complement of the stored owner
  assign sys_rdata = {sys_see_v[sys_idx], ~owner_v[sys_idx],
                      6'h00};                             // R03 R06 R08
  assign sys_ok    = sys_evt && sys_in_rng;
  assign sys_rd_ok = sys_ok & system_read_write_i;
  assign sys_wr_ok = sys_ok & ~system_read_write_i;
  // both sides on one register in one cycle: arbitrated in the cell
  assign clash     = sys_ok && loc_acc_i.req &&
                     (loc_acc_i.idx == sys_idx);            // R11

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------
  logic       loc_vld_q;
  logic [7:0] loc_dat_q;
  logic [7:0] sys_dat_q;
  logic       sys_oe_q;
  logic       sys_ack_q;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q     <= 1'b0;
      loc_vld_q <= 1'b0;
      loc_dat_q <= 8'h00;
      sys_dat_q <= 8'h00;
      sys_oe_q  <= 1'b0;
      sys_ack_q <= 1'b0;
    end else begin
      sel_q     <= system_sel_i;
      loc_vld_q <= loc_acc_i.req & loc_acc_i.rd;
      loc_dat_q <= loc_rdata;                                        // R01
      sys_dat_q <= sys_rdata;                                        // R01
      sys_oe_q  <= sys_rd_ok;
      sys_ack_q <= sys_ok;
    end
  end

  assign loc_rsp_o.valid        = loc_vld_q;
  assign loc_rsp_o.data         = loc_dat_q;
  assign system_bus_lines_o     = sys_dat_q;
  assign system_bus_lines_oe_o  = sys_oe_q;
  assign system_ack_o           = sys_ack_q;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  low_bits_zero_a: assert property (  // R08
    @(posedge clk_sys_i) disable iff (rst_i)
    loc_rsp_o.valid |-> (loc_rsp_o.data[5:0] == 6'h00))
    else $error("local read low bits not zero");

  lone_read_a: assert property (  // R01
    @(posedge clk_sys_i) disable iff (rst_i)
    (loc_acc_i.req && loc_acc_i.rd && loc_ok && !sys_evt) |=>
      (lock_v[$past(loc_acc_i.idx)] &&
       loc_rsp_o.data[7] == $past(lock_v[loc_acc_i.idx])))
    else $error("lone read did not return and set flag");

  lone_write_a: assert property (  // R02
    @(posedge clk_sys_i) disable iff (rst_i)
    (loc_acc_i.req && !loc_acc_i.rd && loc_ok && !sys_evt) |=>
      !lock_v[$past(loc_acc_i.idx)])
    else $error("write did not clear flag");

  sys_ack_one_a: assert property (  // R10
    @(posedge clk_sys_i) disable iff (rst_i)
    system_ack_o |=> !system_ack_o)
    else $error("system answer longer than one cycle");

  owner_pair_a: assert property (  // R06
    @(posedge clk_sys_i) disable iff (rst_i)
    (system_ack_o && system_bus_lines_oe_o) |->
      (system_bus_lines_o[6] == ~$past(owner_v[sys_idx])))
    else $error("owner flag not complemented");

  // ---------------------------------------------------------------------
  // checks: system side, clashes, unmapped local index, owner moves, reset
  // ---------------------------------------------------------------------
  sys_lone_read_a: assert property (  // R01
    @(posedge clk_sys_i) disable iff (rst_i)
    (sys_rd_ok && !clash) |=>
      (lock_v[$past(sys_idx)] &&
       system_bus_lines_o[7] == $past(lock_v[sys_idx])))
    else $error("system read did not return and set flag");

  sys_write_clear_a: assert property (  // R02
    @(posedge clk_sys_i) disable iff (rst_i)
    (sys_wr_ok && !clash) |=> !lock_v[$past(sys_idx)])
    else $error("system write did not clear flag");

  clash_local_true_a: assert property (  // R03
    @(posedge clk_sys_i) disable iff (rst_i)
    (clash && loc_acc_i.rd) |=>
      (loc_rsp_o.data[7] == $past(lock_v[sys_idx])))
    else $error("local side read a false flag in a clash");

  clash_sys_true_a: assert property (  // R03
    @(posedge clk_sys_i) disable iff (rst_i)
    (clash && sys_rd_ok && !(loc_acc_i.rd && !lock_v[sys_idx])) |=>
      (system_bus_lines_o[7] == $past(lock_v[sys_idx])))
    else $error("system side read a false flag in a clash");

  tie_sys_sees_set_a: assert property (  // R04
    @(posedge clk_sys_i) disable iff (rst_i)
    (clash && sys_rd_ok && loc_acc_i.rd && !lock_v[sys_idx]) |=>
      (system_bus_lines_o[7] && !loc_rsp_o.data[7]))
    else $error("tie on clear flag not resolved to local side");

  sys_oe_rw_a: assert property (  // R10
    @(posedge clk_sys_i) disable iff (rst_i)
    sys_ok |=> (system_ack_o &&
                system_bus_lines_oe_o == $past(system_read_write_i)))
    else $error("system answer or drive enable wrong");

  out_of_range_a: assert property (  // R09
    @(posedge clk_sys_i) disable iff (rst_i)
    (sys_evt && !sys_in_rng && !loc_acc_i.req) |=>
      (!system_ack_o && $stable(lock_v) && $stable(owner_v)))
    else $error("unmapped system access had an effect");

  sys_low_bits_a: assert property (  // R08
    @(posedge clk_sys_i) disable iff (rst_i)
    system_bus_lines_oe_o |-> (system_bus_lines_o[5:0] == 6'h00))
    else $error("system read low bits not zero");

  loc_unmapped_a: assert property (  // R08
    @(posedge clk_sys_i) disable iff (rst_i)
    (loc_acc_i.req && loc_acc_i.rd && !loc_ok) |=>
      (loc_rsp_o.data == 8'h00))
    else $error("unmapped local read not zero");

  owner_moves_a: assert property (  // R06
    @(posedge clk_sys_i) disable iff (rst_i)
    ((owner_v ^ $past(owner_v)) & ~(lock_v & ~$past(lock_v))) == '0)
    else $error("owner flag moved without a new lock");

  // no disable: checks the state that reset itself leaves behind
  reset_state_a: assert property (  // R07
    @(posedge clk_sys_i)
    rst_i |=> ((&lock_v) &&
               (owner_v == ~(NSEM'(1) << sem_pkg::SYS_OWNED_IDX))))
    else $error("reset state of flags wrong");

endmodule // sem_regs

//--- tb/sys_proc_model.sv
// Purpose: system processor on the shared bus, one access per select
// Assumes: the unit answers an in-range access with a one-cycle ack
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
module sys_proc_model (
  input  wire logic       clk_sys_i, // system clock
  input  wire logic       ack_i,     // access answer
  output logic            sel_o,     // select, active high
  output logic            rw_o,      // 1 read, 0 write
  output logic [7:0]      addr_o     // byte address
);
  initial begin
    sel_o = 1'b0;
    rw_o = 1'b0;
    addr_o = 8'h00;
  end

  // held until the falling edge after the one that samples ack, then a full cycle deselected
  task automatic access(input logic rd, input logic [7:0] a,
                        output logic got);
    int n;
    got = 1'b0;
    n = 0;
    @(negedge clk_sys_i);
    sel_o = 1'b1;
    rw_o = rd;
    addr_o = a;
    while (!got && n < 4) begin
      @(negedge clk_sys_i);
      got = ack_i;
      n++;
    end
    @(negedge clk_sys_i);
    sel_o = 1'b0;
    rw_o = ~rd;
    addr_o = ~a;
  endtask
endmodule // sys_proc_model

//--- tb/sem_regs_test.sv
// Purpose: self-checking bench for the shared semaphore registers
// Assumes: design answers one cycle after each access
// Notes:   expected bytes queue per side, popped when an answer shows
`timescale 1ns/1ps
module sem_regs_test;
  logic              clk_sys_i = 1'b0;
  logic              rst_i = 1'b1;
  sem_pkg::sem_acc_t loc_acc_i = '0;
  sem_pkg::sem_rsp_t loc_rsp_o;
  logic              sel, rw, ack, oe, got;
  logic [7:0]        addr, sdata;
  logic              lock [6];
  logic              own [6]; // 1 = local cpu set it
  logic [7:0]        lq [$];
  logic [7:0]        sq [$];
  int                miscompares = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                seed = 32'hb970;
  int                r;

  always #2.5 clk_sys_i = ~clk_sys_i;

  sem_regs u_sem_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .loc_acc_i(loc_acc_i), .loc_rsp_o(loc_rsp_o), .system_sel_i(sel),
    .system_read_write_i(rw), .system_addr_i(addr),
    .system_bus_lines_o(sdata), .system_bus_lines_oe_o(oe),
    .system_ack_o(ack));
  sys_proc_model u_sys_proc_model (.clk_sys_i(clk_sys_i), .ack_i(ack),
    .sel_o(sel), .rw_o(rw), .addr_o(addr));

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // ---------------------------------------------------------------
  // reference: lock and owner after one possibly contested access
  // ---------------------------------------------------------------
  function automatic void step(logic le, lr, se, sr, logic [2:0] i);
    logic o, rd, wr, n;
    o = lock[i];
    rd = (le && lr) || (se && sr);
    wr = (le && !lr) || (se && !sr);
    if (le && lr) lq.push_back({o, own[i], 6'h00});
    // system reads the true flag, except a tie on a clear one
    if (se && sr)
      sq.push_back({(le && lr && !o) ? 1'b1 : o, ~own[i], 6'h00});
    n = (rd && wr) ? ~o : rd;
    if (!o && n) own[i] = le && lr; // local wins a tie
    lock[i] = n;
  endfunction

  task automatic loc_op(logic rd, logic [2:0] i);
    @(negedge clk_sys_i);
    loc_acc_i <= '{req: 1'b1, rd: rd, idx: i};
    @(negedge clk_sys_i);
    loc_acc_i.req <= 1'b0;
  endtask

  // both sides start on the same falling edge, so they clash
  task automatic op(logic le, lr, se, sr, logic [2:0] i);
    logic g;
    step(le, lr, se, sr, i);
    fork
      if (le) loc_op(lr, i);
      if (se) begin
        u_sys_proc_model.access(sr, sem_pkg::SYS_BASE + 8'(i), g);
        check({7'h00, g}, 8'h01);
      end
    join
  endtask

  always @(negedge clk_sys_i) begin
    if (loc_rsp_o.valid === 1'b1)
      check(loc_rsp_o.data, lq.size() ? lq.pop_front() : 8'hXX);
    if (ack === 1'b1 && oe === 1'b1)
      check(sdata, sq.size() ? sq.pop_front() : 8'hXX);
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    for (int k = 0; k < 6; k++) begin
      lock[k] = 1'b1;
      own[k] = (k != 1);
    end
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int k = 0; k < 6; k++) op(0, 0, 1, 1, 3'(k));
    for (int k = 0; k < 6; k++) op(1, 1, 0, 0, 3'(k));
    for (int k = 0; k < 6; k++) begin
      op(1, 0, 0, 0, 3'(k));
      op(0, 0, 1, 1, 3'(k));
      op(1, 1, 0, 0, 3'(k));
      op(0, 0, 1, 0, 3'(k));
      op(1, 1, 0, 0, 3'(k));
    end
    for (int c = 0; c < 8; c++) begin
      if (c[2]) op(1, 1, 0, 0, 3'(c % 6));
      else op(0, 0, 1, 0, 3'(c % 6));
      op(1, c[1], 1, c[0], 3'(c % 6));
      op(1, 1, 0, 0, 3'(c % 6));
    end
    op(1, 1, 0, 0, 3'd0);
    op(1, 1, 0, 0, 3'd5);
    u_sys_proc_model.access(1'b0, 8'h16, got);
    check({7'h00, got}, 8'h00);
    u_sys_proc_model.access(1'b0, 8'h1D, got);
    check({7'h00, got}, 8'h00);
    op(1, 1, 0, 0, 3'd0);
    op(1, 1, 0, 0, 3'd5);
    lq.push_back(8'h00);
    loc_op(1'b1, 3'd6);
    repeat (60) begin
      r = $random(seed);
      op(r[0] | ~r[2], r[1], r[2], r[3], 3'(r[7:4] % 6));
    end
    repeat (4) @(negedge clk_sys_i);
    check(8'(lq.size() + sq.size()), 8'h00);
    print_verdict();
  end
endmodule // sem_regs_test
